// [dv/alm_term.sv]
// serial terminal model at the line side: sends and receives 5n1 frames
`timescale 1ns/1ps
`default_nettype none
`include "alm_params.svh"
module alm_term (
	// clock
	input  wire logic       aclk,
	// serial line
	input  wire logic       serial_out,
	output logic            serial_in,
	// control and result
	input  wire logic       arm,
	output logic [7:0]      got,
	output logic            got_ok
);
	localparam int BIT = 16 * `ALM_TX_TICK_CYC;
	localparam int BIT_RX = 16 * `ALM_RX_TICK_CYC;
	localparam int NB  = 5;
	// the line idles at mark between frames, so no stale level is left behind
	// frames toward the block are timed at its receive rate, not its transmit rate
	task automatic send(input logic [7:0] b);
		serial_in <= 1'b0;
		repeat (BIT_RX) @(posedge aclk);
		for (int i = 0; i < NB; i++) begin
			serial_in <= b[i];
			repeat (BIT_RX) @(posedge aclk);
		end
		serial_in <= 1'b1;
		repeat (BIT_RX) @(posedge aclk);
	endtask
	// samples at bit centres; arm keeps a break from looking like a frame
	initial begin
		serial_in = 1'b1;
		got = 8'h00;
		got_ok = 1'b0;
		forever begin
			@(posedge aclk);
			if (arm && serial_out === 1'b0) begin
				repeat (BIT / 2) @(posedge aclk);
				for (int i = 0; i < NB; i++) begin
					repeat (BIT) @(posedge aclk);
					got[i] <= serial_out;
				end
				repeat (BIT) @(posedge aclk);
				got_ok <= (serial_out === 1'b1);
			end
		end
	end
endmodule
`default_nettype wire

// [dv/alm_top_tb.sv]
// self-checking bench: register bus, modem lines, break, one frame each way
`timescale 1ns/1ps
`default_nettype none
module alm_top_tb;
	import alm_pkg::*;
	logic           aclk = 1'b0;
	logic           aresetn = 1'b0;
	logic           awvalid, awready, wvalid, wready, bvalid, bready;
	logic           arvalid, arready, rvalid, rready;
	logic [7:0]     awaddr, araddr, got;
	logic [31:0]    wdata, rdata;
	logic [1:0]     bresp, rresp;
	logic [1:0]     wr_resp;
	logic           serial_in, serial_out, tape_step_request, arm, got_ok;
	logic           rx_irq, tx_irq, modem_irq;
	alm_modem_in_t  modem_in;
	alm_modem_out_t modem_out;
	int             seed = 29;
	int             error_cnt = 0;
	int             n_compared = 0;
	logic [7:0]     exp_q[$];
	always #5 aclk = ~aclk;
	alm_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .cfg('0), .serial_in(serial_in),
		.serial_out(serial_out), .modem_in(modem_in), .modem_out(modem_out),
		.tape_step_request(tape_step_request), .rx_irq(rx_irq), .tx_irq(tx_irq),
		.modem_irq(modem_irq));
	alm_term term (.aclk(aclk), .serial_out(serial_out), .serial_in(serial_in),
		.arm(arm), .got(got), .got_ok(got_ok));
	task automatic end_sim;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one edge first so a back-to-back call never drives a signal twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	initial begin
		// the two overlapping 5n1 frames need about 68000 cycles at the default rate
		repeat (90000) @(posedge aclk);
		error_cnt++;
		end_sim;
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  rb;
		{awvalid, wvalid, bready, arvalid, rready, arm} = '0;
		{awaddr, araddr, wdata} = '0;
		modem_in = alm_modem_in_t'($random(seed));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({31'h0, serial_out}, 32'h1);
		rd(8'h10, d, r);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		wr(8'h14, 32'h1);
		chk({30'h0, wr_resp}, 32'h2);
		wr(8'h00, 32'h66);
		chk({30'h0, wr_resp}, 32'h0);
		rd(8'h00, d, r);
		chk(d, {16'h0, 1'b0, modem_in.call_indicator, modem_in.modem_go_ahead,
			modem_in.carrier_present, 1'b0, modem_in.reverse_channel_in, 2'b0, 8'h66});
		chk({29'h0, modem_out}, 32'h6);
		modem_in.carrier_present <= ~modem_in.carrier_present;
		repeat (3) @(posedge aclk);
		chk({31'h0, modem_irq}, 32'h1);
		wr(8'h00, 32'h8066);
		chk({31'h0, modem_irq}, 32'h0);
		wr(8'h08, 32'h41);
		repeat (2) @(posedge aclk);
		chk({31'h0, serial_out}, 32'h0);
		chk({31'h0, tx_irq}, 32'h1);
		wr(8'h08, 32'h40);
		repeat (4) @(posedge aclk);
		arm <= 1'b1;
		exp_q.push_back(8'($random(seed)) & 8'h1F);
		rb = 8'($random(seed)) & 8'h1F;
		wr(8'h0C, {24'h0, exp_q[0]});
		rd(8'h08, d, r);
		chk(d, 32'hC0);
		wr(8'h00, 32'h67);
		chk({31'h0, tape_step_request}, 32'h1);
		fork
			term.send(rb);
		join_none
		wait (rx_irq === 1'b1);
		rd(8'h04, d, r);
		chk(d, {24'h0, rb});
		chk({31'h0, rx_irq}, 32'h0);
		chk({31'h0, tape_step_request}, 32'h0);
		wait (got_ok === 1'b1);
		chk({24'h0, got}, {24'h0, exp_q.pop_front()});
		end_sim;
	end
endmodule
`default_nettype wire

// [logic/alm_params.svh]
// constants for the asynchronous line interface: offsets, fields, timing
`ifndef ALM_PARAMS_SVH
`define ALM_PARAMS_SVH
`define ALM_CLK_HZ        100000000
`define ALM_RX_BAUD       9600
`define ALM_TX_BAUD       9600
`define ALM_OVS           16
`define ALM_RX_TICK_CYC   (`ALM_CLK_HZ / (`ALM_RX_BAUD * `ALM_OVS))
`define ALM_TX_TICK_CYC   (`ALM_CLK_HZ / (`ALM_TX_BAUD * `ALM_OVS))
`define ALM_OFS_RX_STATUS 8'h00
`define ALM_OFS_RX_DATA   8'h04
`define ALM_OFS_TX_STATUS 8'h08
`define ALM_OFS_TX_DATA   8'h0C
`define ALM_RS_MODEM_FLAG 15
`define ALM_RS_CALL       14
`define ALM_RS_GO_AHEAD   13
`define ALM_RS_CARRIER    12
`define ALM_RS_IN_PROG    11
`define ALM_RS_REV_IN     10
`define ALM_RS_READY      7
`define ALM_RS_RX_IE      6
`define ALM_RS_MODEM_IE   5
`define ALM_RS_REV_OUT    3
`define ALM_RS_SEND_REQ   2
`define ALM_RS_TERM_RDY   1
`define ALM_RS_STEP       0
`define ALM_RD_ERROR      15
`define ALM_RD_OVERRUN    14
`define ALM_RD_FRAMING    13
`define ALM_RD_PARITY     12
`define ALM_TS_EMPTY      7
`define ALM_TS_TX_IE      6
`define ALM_TS_LOOPBACK   2
`define ALM_TS_BREAK      0
`define ALM_BIT_LAST      4'hF
`define ALM_START_CENTER  4'h7
`define ALM_STOP1_LAST    6'h0F
`define ALM_STOP15_LAST   6'h17
`define ALM_STOP2_LAST    6'h1F
`define ALM_RESP_OKAY     2'h0
`define ALM_RESP_SLVERR   2'h2
`endif

// [logic/alm_pkg.sv]
// types shared by the asynchronous line interface
package alm_pkg;
	typedef struct packed {
		logic       length_code_high;
		logic       length_code_low;
		logic       parity_enable_cfg;
		logic       parity_select_cfg;
		logic [1:0] stop_count_cfg;
	} alm_cfg_t;
	typedef struct packed {
		logic call_indicator;
		logic carrier_present;
		logic modem_go_ahead;
		logic reverse_channel_in;
	} alm_modem_in_t;
	typedef struct packed {
		logic terminal_ready;
		logic send_request_out;
		logic reverse_channel_out;
	} alm_modem_out_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} alm_rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} alm_tx_state_t;
	typedef enum logic [2:0] {
		REG_RX_STATUS,
		REG_RX_DATA,
		REG_TX_STATUS,
		REG_TX_DATA,
		REG_NONE
	} alm_reg_t;
endpackage

// [logic/alm_top.sv]
// asynchronous line interface with modem control behind an axi4-lite slave
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`include "alm_params.svh"
`timescale 1ns/1ps
`default_nettype none

module alm_top (
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite slave
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [7:0]              awaddr,
	input  wire logic [2:0]              awprot,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [7:0]              araddr,
	input  wire logic [2:0]              arprot,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	// static character format
	input  wire alm_pkg::alm_cfg_t       cfg,
	// serial line and modem
	input  wire logic                    serial_in,
	output logic                         serial_out,
	input  wire alm_pkg::alm_modem_in_t  modem_in,
	output var alm_pkg::alm_modem_out_t  modem_out,
	output logic                         tape_step_request,
	// interrupt requests
	output logic                         rx_irq,
	output logic                         tx_irq,
	output logic                         modem_irq
);
	import alm_pkg::*;

	function automatic alm_reg_t decode(input logic [7:0] a);
		case (a)
			`ALM_OFS_RX_STATUS: decode = REG_RX_STATUS;
			`ALM_OFS_RX_DATA:   decode = REG_RX_DATA;
			`ALM_OFS_TX_STATUS: decode = REG_TX_STATUS;
			`ALM_OFS_TX_DATA:   decode = REG_TX_DATA;
			default:            decode = REG_NONE;
		endcase
	endfunction

	function automatic logic [7:0] len_mask(input logic [1:0] code);
		case (code)
			2'h0:    len_mask = 8'h1F;
			2'h1:    len_mask = 8'h3F;
			2'h2:    len_mask = 8'h7F;
			default: len_mask = 8'hFF;
		endcase
	endfunction

	// bit-rate ticks at sixteen times the rate, index 0 receive, 1 transmit
	logic [1:0]    tick;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tick
			localparam int unsigned DIV = (g == 0) ? `ALM_RX_TICK_CYC : `ALM_TX_TICK_CYC;
			logic [11:0] cnt;
			logic        pulse;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt <= 12'h000;
					pulse <= 1'b0;
				end else if (cnt == 12'(DIV - 1)) begin
					cnt <= 12'h000;
					pulse <= 1'b1;
				end else begin
					cnt <= cnt + 12'h001;
					pulse <= 1'b0;
				end
			end
			assign tick[g] = pulse;
		end
	endgenerate

	// format: length, mask and parity shared by both directions, stop count used by the transmitter only
	logic [1:0]    len_code;
	logic [2:0]    last_bit;
	logic [7:0]    mask;
	logic [5:0]    stop_last;
	assign len_code = {cfg.length_code_high, cfg.length_code_low};
	assign last_bit = {1'b0, len_code} + 3'h4;
	assign mask = len_mask(len_code);
	always_comb begin
		case (cfg.stop_count_cfg)
			2'h0:    stop_last = `ALM_STOP1_LAST;
			2'h1:    stop_last = `ALM_STOP15_LAST;
			default: stop_last = `ALM_STOP2_LAST;
		endcase
	end

	// register bus: write and read are each taken in one edge
	logic          wr_take;
	logic          rd_take;
	alm_reg_t      wr_reg;
	alm_reg_t      rd_reg;
	assign wr_take = awvalid & wvalid & ~bvalid;
	assign rd_take = arvalid & ~rvalid;
	assign awready = wr_take;
	assign wready = wr_take;
	assign arready = rd_take;
	assign wr_reg = decode(awaddr);
	assign rd_reg = decode(araddr);

	logic          wr_rs;
	logic          wr_ts;
	logic          wr_txd;
	logic          step_set;
	logic          modem_clr;
	logic          rd_rxd;
	assign wr_rs = wr_take && wr_reg == REG_RX_STATUS && wstrb[0];
	assign wr_ts = wr_take && wr_reg == REG_TX_STATUS && wstrb[0];
	assign wr_txd = wr_take && wr_reg == REG_TX_DATA && wstrb[0];
	assign step_set = wr_rs && wdata[`ALM_RS_STEP];
	assign modem_clr = wr_take && wr_reg == REG_RX_STATUS && wstrb[1] && wdata[`ALM_RS_MODEM_FLAG];
	assign rd_rxd = rd_take && rd_reg == REG_RX_DATA;

	// host control bits
	logic          rx_irq_enable;
	logic          modem_irq_enable;
	logic          tx_irq_enable;
	logic          loopback_test_bit;
	logic          brk;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_irq_enable <= 1'b0;
			modem_irq_enable <= 1'b0;
			modem_out <= '0;
		end else if (wr_rs) begin
			rx_irq_enable <= wdata[`ALM_RS_RX_IE];
			modem_irq_enable <= wdata[`ALM_RS_MODEM_IE];
			modem_out.reverse_channel_out <= wdata[`ALM_RS_REV_OUT];
			modem_out.send_request_out <= wdata[`ALM_RS_SEND_REQ];
			modem_out.terminal_ready <= wdata[`ALM_RS_TERM_RDY];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_irq_enable <= 1'b0;
			loopback_test_bit <= 1'b0;
			brk <= 1'b0;
		end else if (wr_ts) begin
			tx_irq_enable <= wdata[`ALM_TS_TX_IE];
			loopback_test_bit <= wdata[`ALM_TS_LOOPBACK];
			brk <= wdata[`ALM_TS_BREAK];
		end
	end

	// transmitter: holding register ahead of the shifter
	logic [7:0]    tx_hold;
	logic          tx_hold_full;
	logic          tx_holding_empty;
	logic          tx_load;
	alm_tx_state_t tx_state;
	logic [5:0]    tx_tcnt;
	logic [2:0]    tx_bit;
	logic [7:0]    tx_shift;
	logic          tx_par;
	logic          next_line;
	assign tx_load = tx_state == TX_IDLE && tx_hold_full;
	assign tx_holding_empty = ~tx_hold_full;
	// a write while full overwrites the waiting character; software should poll the flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold <= 8'h00;
			tx_hold_full <= 1'b0;
		end else if (wr_txd) begin
			tx_hold <= wdata[7:0];
			tx_hold_full <= 1'b1;
		end else if (tx_load) begin
			tx_hold_full <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state <= TX_IDLE;
			tx_tcnt <= 6'h00;
			tx_bit <= 3'h0;
			tx_shift <= 8'h00;
			tx_par <= 1'b0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift <= tx_hold & mask;
						tx_par <= ^(tx_hold & mask) ^ ~cfg.parity_select_cfg;
						tx_tcnt <= 6'h00;
						tx_state <= TX_START;
					end
				end
				TX_START: begin
					if (tick[1] && tx_tcnt[3:0] == `ALM_BIT_LAST) begin
						tx_tcnt <= 6'h00;
						tx_bit <= 3'h0;
						tx_state <= TX_DATA;
					end else if (tick[1]) begin
						tx_tcnt <= tx_tcnt + 6'h01;
					end
				end
				TX_DATA: begin
					if (tick[1] && tx_tcnt[3:0] == `ALM_BIT_LAST) begin
						tx_tcnt <= 6'h00;
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_bit <= tx_bit + 3'h1;
						if (tx_bit == last_bit) begin
							tx_state <= cfg.parity_enable_cfg ? TX_PAR : TX_STOP;
						end
					end else if (tick[1]) begin
						tx_tcnt <= tx_tcnt + 6'h01;
					end
				end
				TX_PAR: begin
					if (tick[1] && tx_tcnt[3:0] == `ALM_BIT_LAST) begin
						tx_tcnt <= 6'h00;
						tx_state <= TX_STOP;
					end else if (tick[1]) begin
						tx_tcnt <= tx_tcnt + 6'h01;
					end
				end
				TX_STOP: begin
					if (tick[1] && tx_tcnt == stop_last) begin
						tx_tcnt <= 6'h00;
						tx_state <= TX_IDLE;
					end else if (tick[1]) begin
						tx_tcnt <= tx_tcnt + 6'h01;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end
	always_comb begin
		case (tx_state)
			TX_START: next_line = 1'b0;
			TX_DATA:  next_line = tx_shift[0];
			TX_PAR:   next_line = tx_par;
			default:  next_line = 1'b1;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_out <= 1'b1;
		end else begin
			serial_out <= next_line & ~brk;
		end
	end

	// receiver: in loopback it hears the transmitter at the transmit rate
	logic          rx_line;
	logic          rx_tick;
	alm_rx_state_t rx_state;
	logic [3:0]    rx_tcnt;
	logic [2:0]    rx_bit;
	logic [7:0]    rx_shift;
	logic          rx_par_in;
	logic          start_ok;
	logic          rx_done;
	assign rx_line = loopback_test_bit ? serial_out : serial_in;
	assign rx_tick = loopback_test_bit ? tick[1] : tick[0];
	assign start_ok = rx_state == RX_START && rx_tick && rx_tcnt == `ALM_START_CENTER && !rx_line;
	assign rx_done = rx_state == RX_STOP && rx_tick && rx_tcnt == `ALM_BIT_LAST;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state <= RX_IDLE;
			rx_tcnt <= 4'h0;
			rx_bit <= 3'h0;
			rx_shift <= 8'h00;
			rx_par_in <= 1'b0;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (rx_tick && !rx_line) begin
						rx_tcnt <= 4'h0;
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					if (rx_tick && rx_tcnt == `ALM_START_CENTER) begin
						// a glitch shorter than half a bit is not a start
						rx_state <= rx_line ? RX_IDLE : RX_DATA;
						rx_tcnt <= 4'h0;
						rx_bit <= 3'h0;
						rx_shift <= 8'h00;
					end else if (rx_tick) begin
						rx_tcnt <= rx_tcnt + 4'h1;
					end
				end
				RX_DATA: begin
					if (rx_tick && rx_tcnt == `ALM_BIT_LAST) begin
						rx_shift[rx_bit] <= rx_line;
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == last_bit) begin
							rx_state <= cfg.parity_enable_cfg ? RX_PAR : RX_STOP;
						end
					end
					if (rx_tick) begin
						rx_tcnt <= rx_tcnt + 4'h1;
					end
				end
				RX_PAR: begin
					if (rx_tick && rx_tcnt == `ALM_BIT_LAST) begin
						rx_par_in <= rx_line;
						rx_state <= RX_STOP;
					end
					if (rx_tick) begin
						rx_tcnt <= rx_tcnt + 4'h1;
					end
				end
				RX_STOP: begin
					if (rx_done) begin
						rx_state <= RX_IDLE;
					end
					if (rx_tick) begin
						rx_tcnt <= rx_tcnt + 4'h1;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// receive holding register and its flags
	logic [7:0]    rx_data;
	logic          overrun_flag;
	logic          rx_framing_flag;
	logic          parity_flag;
	logic          rx_char_ready;
	logic          rx_in_progress;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data <= 8'h00;
			overrun_flag <= 1'b0;
			rx_framing_flag <= 1'b0;
			parity_flag <= 1'b0;
		end else if (rx_done) begin
			rx_data <= rx_shift & mask;
			overrun_flag <= rx_char_ready;
			rx_framing_flag <= ~rx_line;
			parity_flag <= cfg.parity_enable_cfg
				& (rx_par_in ^ ^(rx_shift & mask) ^ ~cfg.parity_select_cfg);
		end
	end
	// the hardware set wins over a read or step request in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_char_ready <= 1'b0;
		end else if (rx_done) begin
			rx_char_ready <= 1'b1;
		end else if (rd_rxd || step_set) begin
			rx_char_ready <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_in_progress <= 1'b0;
			tape_step_request <= 1'b0;
		end else begin
			if (start_ok) begin
				rx_in_progress <= 1'b1;
			end else if (rx_done) begin
				rx_in_progress <= 1'b0;
			end
			if (step_set) begin
				tape_step_request <= 1'b1;
			end else if (start_ok) begin
				tape_step_request <= 1'b0;
			end
		end
	end

	// modem line change detect; inputs are taken as synchronous
	alm_modem_in_t modem_prev;
	logic          modem_flag;
	always_ff @(posedge aclk) begin
		modem_prev <= modem_in;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modem_flag <= 1'b0;
		end else if (modem_prev != modem_in) begin
			modem_flag <= 1'b1;
		end else if (modem_clr) begin
			modem_flag <= 1'b0;
		end
	end

	assign rx_irq = rx_char_ready & rx_irq_enable;
	assign tx_irq = tx_holding_empty & tx_irq_enable;
	assign modem_irq = modem_flag & modem_irq_enable;

	// read data and answers
	logic [31:0]   next_rdata;
	always_comb begin
		next_rdata = 32'h00000000;
		case (rd_reg)
			REG_RX_STATUS: begin
				next_rdata[`ALM_RS_MODEM_FLAG] = modem_flag;
				next_rdata[`ALM_RS_CALL] = modem_in.call_indicator;
				next_rdata[`ALM_RS_GO_AHEAD] = modem_in.modem_go_ahead;
				next_rdata[`ALM_RS_CARRIER] = modem_in.carrier_present;
				next_rdata[`ALM_RS_IN_PROG] = rx_in_progress;
				next_rdata[`ALM_RS_REV_IN] = modem_in.reverse_channel_in;
				next_rdata[`ALM_RS_READY] = rx_char_ready;
				next_rdata[`ALM_RS_RX_IE] = rx_irq_enable;
				next_rdata[`ALM_RS_MODEM_IE] = modem_irq_enable;
				next_rdata[`ALM_RS_REV_OUT] = modem_out.reverse_channel_out;
				next_rdata[`ALM_RS_SEND_REQ] = modem_out.send_request_out;
				next_rdata[`ALM_RS_TERM_RDY] = modem_out.terminal_ready;
				next_rdata[`ALM_RS_STEP] = tape_step_request;
			end
			REG_RX_DATA: begin
				next_rdata[`ALM_RD_ERROR] = overrun_flag | rx_framing_flag | parity_flag;
				next_rdata[`ALM_RD_OVERRUN] = overrun_flag;
				next_rdata[`ALM_RD_FRAMING] = rx_framing_flag;
				next_rdata[`ALM_RD_PARITY] = parity_flag;
				next_rdata[7:0] = rx_data;
			end
			REG_TX_STATUS: begin
				next_rdata[`ALM_TS_EMPTY] = tx_holding_empty;
				next_rdata[`ALM_TS_TX_IE] = tx_irq_enable;
				next_rdata[`ALM_TS_LOOPBACK] = loopback_test_bit;
				next_rdata[`ALM_TS_BREAK] = brk;
			end
			default: next_rdata = 32'h00000000;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `ALM_RESP_OKAY;
		end else if (wr_take) begin
			bvalid <= 1'b1;
			bresp <= (wr_reg == REG_NONE) ? `ALM_RESP_SLVERR : `ALM_RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `ALM_RESP_OKAY;
		end else if (rd_take) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= (rd_reg == REG_NONE) ? `ALM_RESP_SLVERR : `ALM_RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_stop_center;
		rx_state == RX_STOP && rx_tick && rx_tcnt == `ALM_BIT_LAST;
	endsequence
	sequence s_start_center;
		rx_state == RX_START && rx_tick && rx_tcnt == `ALM_START_CENTER && !rx_line;
	endsequence
	a_done_at_stop: assert property (s_stop_center |=> rx_char_ready && !rx_in_progress)
		else $error("done flag not set at stop centre");
	a_overrun_set: assert property (s_stop_center and rx_char_ready |=> overrun_flag)
		else $error("overrun not flagged");
	// a step request in the start-centre cycle wins, so the step output may stay up
	a_in_progress_set: assert property (s_start_center |=>
		rx_in_progress && (!tape_step_request || $past(step_set)))
		else $error("in-progress not set at start centre");
	a_break_space: assert property (brk |=> !serial_out)
		else $error("line not at space during break");
	a_ready_clear: assert property (wr_txd |=> !tx_holding_empty)
		else $error("ready flag not cleared by data write");
	a_idle_load: assert property (tx_state == TX_IDLE && tx_hold_full && !wr_txd
		|=> tx_holding_empty && tx_state == TX_START ##1 !serial_out || brk)
		else $error("idle shifter did not take holding character");
	a_wait_frame: assert property (tx_state != TX_IDLE && tx_hold_full && !wr_txd
		|=> tx_hold_full)
		else $error("holding character left before frame end");
	a_step_clear: assert property (step_set && !rx_done |=> tape_step_request && !rx_char_ready)
		else $error("step request did not clear done");
	a_modem_change: assert property (modem_prev != modem_in && modem_irq_enable
		|=> modem_irq || !modem_irq_enable)
		else $error("modem change did not interrupt");
	a_rx_irq_gate: assert property ($rose(rx_irq) |-> $past(rx_done) && rx_irq_enable
		|| !$past(rx_irq_enable))
		else $error("receive irq without cause");
endmodule
`default_nettype wire
